// [src/pmbfe_pkg.sv]
// Purpose: shared constants and types for the management bus slave front end
// Assumes: 100 MHz REF_CLK, bus pins sampled synchronously
// Notes: strap levels above 7 mean the strap reads out of range
package pmbfe_pkg;
  localparam int CLK_MHZ = 100;
  localparam int BUS_STD_KHZ = 100;
  localparam int BUS_FAST_KHZ = 400;
  localparam int DATA_HOLD_NS = 300;
  localparam int DATA_HOLD_CYC = (DATA_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int FAST_LOW_NS = 1300;
  localparam int FAST_LOW_CYC = FAST_LOW_NS * CLK_MHZ / 1000;
  localparam int HOLD_W = 6;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(DATA_HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_LAST = 6'h01;

  localparam logic [6:0] ADDR_FALLBACK = 7'h7F;
  localparam logic [6:0] ADDR_ALERT_RESP = 7'h0C;
  localparam logic [3:0] STRAP_MAX = 4'h7;
  localparam int STRAP_RADIX = 8;

  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ONOFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] ONOFF_CONFIG_RST = 8'h16;
  localparam logic [7:0] OPERATION_RST = 8'h00;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam int ONOFF_PU = 4;
  localparam int ONOFF_CMD = 3;
  localparam int ONOFF_CPR = 2;
  localparam int ONOFF_POL = 1;
  localparam int OPER_ON = 7;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [2:0] {PS_IDLE, PS_ADDR, PS_RX, PS_ACK, PS_TX, PS_MACK} pmbfe_phase_t;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] data;
    logic pec;
  } pmbfe_cmd_t;

  // data bytes that follow the command code on a write
  function automatic logic [1:0] pmbfe_cmd_len(input logic [7:0] code);
    pmbfe_cmd_len = 2'h0;
    if (code == CMD_OPERATION || code == CMD_ONOFF_CONFIG) pmbfe_cmd_len = 2'h1;
    if (code == CMD_VOUT_COMMAND) pmbfe_cmd_len = 2'h2;
  endfunction : pmbfe_cmd_len
endpackage : pmbfe_pkg

// [src/pmbfe_crc8.sv]
// Purpose: running packet check value over every byte of a transaction
// Assumes: clr and upd never both matter in one cycle; clr wins
// Notes: polynomial x^8+x^2+x+1, byte folded in msb first
`timescale 1ns/1ps
module pmbfe_crc8 import pmbfe_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic clr, // restart at a new transaction
  input wire logic upd, // fold in byte_in
  input wire logic [7:0] byte_in, // byte just passed on the bus
  output logic [7:0] crc // current check value
);
  typedef struct packed {logic [7:0] crc;} pmbfe_crc_state_t;
  pmbfe_crc_state_t crc_reg, crc_next;

  always_comb begin
    logic [7:0] c;
    c = crc_reg.crc ^ byte_in;
    crc_next = crc_reg;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    if (clr) crc_next.crc = CRC_INIT;
    else if (upd) crc_next.crc = c;
  end

  always_ff @(posedge clk) begin
    if (rst) crc_reg <= '{crc: CRC_INIT};
    else crc_reg <= crc_next;
  end

  assign crc = crc_reg.crc;
endmodule : pmbfe_crc8

// [src/pmbfe_slave.sv]
// Purpose: slave front end of a management bus: addressing, framing, check byte, alert, on/off
// Assumes: SCL_IN and SDA_IN already synchronous; master drives the clock
// Notes: only OPERATION and on/off configuration are held here; every accepted write, these two included, goes out on CMD
`timescale 1ns/1ps
module pmbfe_slave import pmbfe_pkg::*; (
  input wire logic REF_CLK, // system clock
  input wire logic RST, // synchronous reset, active high
  input wire logic SCL_IN, // bus clock level
  input wire logic SDA_IN, // bus data level
  output logic SDA_OUT, // data drive value, always low
  output logic SDA_OE, // high pulls data low
  output logic ALERT_OUT, // alert drive value, always low
  output logic ALERT_OE, // high pulls alert low
  input wire logic [3:0] ADDR_STRAP_LOW_DIGIT, // low strap level, above 7 is out of range
  input wire logic [3:0] ADDR_STRAP_HIGH_DIGIT, // high strap level, above 7 is out of range
  input wire logic ONOFF_CONTROL_INPUT, // on/off control pin level
  input wire logic ALERT_REQ, // pulse: condition needs host attention
  output logic CONV_ENABLE, // power conversion allowed
  output logic NVM_STORE, // pulse: commit storable settings
  output logic CMD_STROBE, // pulse: accepted write command on CMD
  output pmbfe_cmd_t CMD, // accepted command, code and data
  output logic [6:0] SLAVE_ADDR // resolved bus address
);
  typedef struct packed {
    pmbfe_phase_t phase;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic ara;
    logic acked;
    logic [2:0] nbytes;
    logic [1:0] txn;
    logic [7:0] cmd;
    logic [15:0] data;
    logic [7:0] operation;
    logic [7:0] onoff;
    logic [6:0] addr;
    logic addr_done;
    logic alert;
    logic [HOLD_W-1:0] hold_cnt;
    logic pend_oe;
    logic sda_oe;
    logic conv_en;
    logic store;
    logic strobe;
    pmbfe_cmd_t cmd_out;
  } pmbfe_state_t;

  localparam pmbfe_state_t STATE_RST = '{phase: PS_IDLE, scl_q: 1'b1, sda_q: 1'b1,
    operation: OPERATION_RST, onoff: ONOFF_CONFIG_RST, default: '0};
  localparam int HOLD_A = DATA_HOLD_CYC;

  pmbfe_state_t r, n;
  logic scl_rise, scl_fall, start_evt, stop_evt;
  logic crc_clr, crc_upd, load;
  logic [7:0] crc_byte, crc_val, tx_byte, rd_value;
  logic [1:0] cmd_len, tx_sel;
  logic len_plain, len_pec;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  assign scl_rise = SCL_IN & ~r.scl_q;
  assign scl_fall = ~SCL_IN & r.scl_q;
  assign start_evt = SCL_IN & r.scl_q & r.sda_q & ~SDA_IN;
  assign stop_evt = SCL_IN & r.scl_q & ~r.sda_q & SDA_IN;
  assign cmd_len = pmbfe_cmd_len(r.cmd);
  assign len_plain = r.nbytes == 3'(cmd_len) + 3'h1;
  assign len_pec = r.nbytes == 3'(cmd_len) + 3'h2;
  assign rd_value = (r.cmd == CMD_OPERATION) ? r.operation :
                    (r.cmd == CMD_ONOFF_CONFIG) ? r.onoff : READ_FILL;
  assign tx_sel = (r.phase == PS_MACK) ? r.txn + 2'h1 : 2'h0;
  // alert response carries the address in the upper seven bits
  assign tx_byte = (tx_sel != 2'h0) ? ((tx_sel == 2'h1) ? crc_val : READ_FILL) :
                   (r.ara ? {r.addr, 1'b0} : rd_value);
  assign load = scl_fall && !start_evt && !stop_evt &&
                ((r.phase == PS_ACK && r.rw) || (r.phase == PS_MACK && r.acked));
  assign crc_byte = load ? tx_byte : r.shreg;

  always_comb begin
    n = r;
    crc_clr = 1'b0;
    crc_upd = 1'b0;
    n.scl_q = SCL_IN;
    n.sda_q = SDA_IN;
    n.store = 1'b0;
    n.strobe = 1'b0;
    if (!r.addr_done) begin
      n.addr_done = 1'b1;
      if (ADDR_STRAP_HIGH_DIGIT > STRAP_MAX || ADDR_STRAP_LOW_DIGIT > STRAP_MAX) n.addr = ADDR_FALLBACK;
      else n.addr = 7'(ADDR_STRAP_HIGH_DIGIT * STRAP_RADIX) + 7'(ADDR_STRAP_LOW_DIGIT);
    end
    // data moves only after the hold time past the clock fall, never while high
    if (r.hold_cnt != '0) begin
      n.hold_cnt = r.hold_cnt - HOLD_LAST;
      if (r.hold_cnt == HOLD_LAST) n.sda_oe = r.pend_oe;
    end
    if (start_evt) begin
      if (r.phase == PS_IDLE) begin
        crc_clr = 1'b1;
        n.nbytes = '0;
        // bytes a short write never sends must not carry over from the last one
        n.data = '0;
      end
      n.phase = PS_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
      n.pend_oe = 1'b0;
      n.hold_cnt = '0;
    end else if (stop_evt) begin
      // the clock rise ahead of a stop shifts in one spare bit
      if (r.phase == PS_RX && !r.rw && r.bitcnt == 4'h1 && (len_plain || (len_pec && crc_val == CRC_INIT))) begin
        n.strobe = 1'b1;
        n.cmd_out = '{code: r.cmd, data: r.data, pec: len_pec};
        if (r.cmd == CMD_OPERATION) n.operation = r.data[7:0];
        if (r.cmd == CMD_ONOFF_CONFIG) n.onoff = r.data[7:0];
        if (r.cmd == CMD_STORE_DEFAULT_ALL || r.cmd == CMD_STORE_USER_ALL) n.store = 1'b1;
      end
      n.phase = PS_IDLE;
      n.sda_oe = 1'b0;
      n.pend_oe = 1'b0;
      n.hold_cnt = '0;
    end else if (scl_rise) begin
      if (r.phase == PS_ADDR || r.phase == PS_RX) begin
        n.shreg = {r.shreg[6:0], SDA_IN};
        n.bitcnt = r.bitcnt + 4'h1;
      end else if (r.phase == PS_TX) begin
        n.bitcnt = r.bitcnt + 4'h1;
      end else if (r.phase == PS_MACK) begin
        n.acked = ~SDA_IN;
        if (r.ara) n.alert = 1'b0;
      end
    end else if (scl_fall) begin
      unique case (r.phase)
        PS_IDLE: ;
        PS_ADDR: if (r.bitcnt == 4'h8) begin
          if ((r.addr_done && r.shreg[7:1] == r.addr) ||
              (r.shreg[7:1] == ADDR_ALERT_RESP && r.shreg[0] && r.alert)) begin
            n.phase = PS_ACK;
            n.rw = r.shreg[0];
            n.ara = !(r.addr_done && r.shreg[7:1] == r.addr);
            n.pend_oe = 1'b1;
            n.hold_cnt = HOLD_LOAD;
            crc_upd = 1'b1;
          end else n.phase = PS_IDLE;
        end
        PS_RX: if (r.bitcnt == 4'h8) begin
          n.phase = PS_ACK;
          n.pend_oe = 1'b1;
          n.hold_cnt = HOLD_LOAD;
          crc_upd = 1'b1;
          if (r.nbytes == 3'h0) n.cmd = r.shreg;
          if (r.nbytes == 3'h1 && cmd_len != 2'h0) n.data[7:0] = r.shreg;
          if (r.nbytes == 3'h2 && cmd_len == 2'h2) n.data[15:8] = r.shreg;
          if (r.nbytes != 3'h7) n.nbytes = r.nbytes + 3'h1;
        end
        PS_ACK: begin
          n.bitcnt = '0;
          n.txn = '0;
          n.phase = r.rw ? PS_TX : PS_RX;
          if (!r.rw) begin
            n.pend_oe = 1'b0;
            n.hold_cnt = HOLD_LOAD;
          end
        end
        PS_TX: begin
          n.hold_cnt = HOLD_LOAD;
          if (r.bitcnt == 4'h8) begin
            n.phase = PS_MACK;
            n.pend_oe = 1'b0;
          end else begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.pend_oe = ~r.shreg[6];
          end
        end
        PS_MACK: if (r.acked) begin
          n.phase = PS_TX;
          n.bitcnt = '0;
          if (r.txn != 2'h3) n.txn = r.txn + 2'h1;
        end else n.phase = PS_IDLE;
      endcase
      if (load) begin
        crc_upd = 1'b1;
        n.shreg = tx_byte;
        n.pend_oe = ~tx_byte[7];
        n.hold_cnt = HOLD_LOAD;
      end
    end
    // a new request in the clearing cycle keeps the alert up
    if (ALERT_REQ) n.alert = 1'b1;
    n.conv_en = (!r.onoff[ONOFF_PU]) ||
                ((!r.onoff[ONOFF_CMD] || r.operation[OPER_ON]) &&
                 (!r.onoff[ONOFF_CPR] || ONOFF_CONTROL_INPUT == r.onoff[ONOFF_POL]));
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) r <= STATE_RST;
    else r <= n;
  end

  pmbfe_crc8 u_crc (
    .clk(REF_CLK),
    .rst(RST),
    .clr(crc_clr),
    .upd(crc_upd),
    .byte_in(crc_byte),
    .crc(crc_val)
  );

  assign SDA_OUT = 1'b0;
  assign ALERT_OUT = 1'b0;
  assign SDA_OE = r.sda_oe;
  assign ALERT_OE = r.alert;
  assign CONV_ENABLE = r.conv_en;
  assign NVM_STORE = r.store;
  assign CMD_STROBE = r.strobe;
  assign CMD = r.cmd_out;
  assign SLAVE_ADDR = r.addr;

  sda_rise_low_a: assert property ($rose(r.sda_oe) |-> !r.scl_q)
    else $error("data pulled low while clock high");
  hold_delay_a: assert property (disable iff (RST || start_evt || stop_evt)
    (r.hold_cnt == HOLD_LOAD && $past(r.hold_cnt) != HOLD_LOAD) |-> ##HOLD_A (r.sda_oe == r.pend_oe))
    else $error("data drive not applied after hold time");
  pec_absent_a: assert property ((stop_evt && r.phase == PS_RX && !r.rw && r.bitcnt == 4'h1 && len_plain)
    |=> (r.strobe && !r.cmd_out.pec))
    else $error("write without check byte not accepted");
  pec_discard_a: assert property ((stop_evt && len_pec && crc_val != CRC_INIT) |=> !r.strobe)
    else $error("bad check byte accepted");
  store_only_a: assert property (r.store |-> (r.strobe && (r.cmd_out.code == CMD_STORE_DEFAULT_ALL ||
    r.cmd_out.code == CMD_STORE_USER_ALL)))
    else $error("store pulse without store command");
  strap_addr_a: assert property ($rose(r.addr_done) |-> (r.addr ==
    (($past(ADDR_STRAP_HIGH_DIGIT) > STRAP_MAX || $past(ADDR_STRAP_LOW_DIGIT) > STRAP_MAX) ? ADDR_FALLBACK :
     7'($past(ADDR_STRAP_HIGH_DIGIT) * STRAP_RADIX) + 7'($past(ADDR_STRAP_LOW_DIGIT)))))
    else $error("slave address not decoded from straps");
  addr_stable_a: assert property (r.addr_done |=> (r.addr_done && $stable(r.addr)))
    else $error("slave address changed after decode");
  ara_refuse_a: assert property ((scl_fall && !start_evt && !stop_evt && r.phase == PS_ADDR &&
    r.bitcnt == 4'h8 && r.shreg == {ADDR_ALERT_RESP, 1'b1} && !r.alert && r.addr != ADDR_ALERT_RESP)
    |=> (r.phase == PS_IDLE && !r.pend_oe))
    else $error("alert response acked without alert");
  alert_raise_a: assert property (ALERT_REQ |=> ALERT_OE [*2])
    else $error("alert request not shown on alert pin");
  onoff_default_a: assert property ((r.onoff == ONOFF_CONFIG_RST) |=>
    (CONV_ENABLE == $past(ONOFF_CONTROL_INPUT)))
    else $error("default on/off not active high");
endmodule : pmbfe_slave

// [verification/pmbfe_host_model.sv]
// Purpose: bus master model that drives clock and data toward the slave
// Assumes: data wire is pulled up; sda_m high means released
// Notes: bit times lo_cyc and hi_cyc are set by the bench per bus rate
`timescale 1ns/1ps
module pmbfe_host_model (
  input wire logic clk, // system clock
  input wire logic sda_wire, // resolved data level
  output logic scl, // bus clock, idle high
  output logic sda_m // master data drive
);
  int lo_cyc = 130;
  int hi_cyc = 70;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  task automatic start();
    sda_m = 1'b1;
    hold(lo_cyc);
    scl = 1'b1;
    hold(hi_cyc);
    sda_m = 1'b0;
    hold(hi_cyc);
    scl = 1'b0;
    hold(1);
  endtask : start
  // stopping before the check byte clocks means no check byte
  task automatic stop();
    sda_m = 1'b0;
    hold(lo_cyc);
    scl = 1'b1;
    hold(hi_cyc);
    sda_m = 1'b1;
    hold(hi_cyc);
  endtask : stop
  // data moves only one cycle after the clock fell, never beside it
  task automatic bit_io(input logic drv, output logic got);
    sda_m = drv;
    hold(lo_cyc);
    scl = 1'b1;
    hold(hi_cyc / 2);
    got = sda_wire;
    hold(hi_cyc - hi_cyc / 2);
    scl = 1'b0;
    hold(1);
  endtask : bit_io
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(b[i], x);
    bit_io(1'b1, x);
    ack = !x;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic x;
    repeat (8) begin
      bit_io(1'b1, x);
      b = {b[6:0], x};
    end
    bit_io(!ack, x);
  endtask : rbyte
endmodule : pmbfe_host_model

// [verification/pmbus_slave_front_end_test.sv]
// Purpose: self-checking bench for the management bus slave front end
// Assumes: host model is the only master; straps change in reset, save one mid-run change that checks the address is held
// Notes: expected commands queue up in the driver, a monitor pops them
`timescale 1ns/1ps
module pmbus_slave_front_end_test import pmbfe_pkg::*;;
  logic ref_clk = 1'b0, rst = 1'b1, onoff = 1'b1, alert_req = 1'b0;
  logic [3:0] strap_lo = 4'h0, strap_hi = 4'h0;
  logic scl, sda_m, sda_oe, sda_out, alert_oe, alert_out, conv_en, nvm_store, cmd_strobe;
  pmbfe_cmd_t cmd;
  logic [6:0] slave_addr, own;
  wire sda_wire = sda_m & ~sda_oe;
  int failures = 0, total_checks = 0;
  logic [25:0] notes[$];
  pmbfe_slave dut_u (.REF_CLK(ref_clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .ADDR_STRAP_LOW_DIGIT(strap_lo),
    .ADDR_STRAP_HIGH_DIGIT(strap_hi), .ONOFF_CONTROL_INPUT(onoff), .ALERT_REQ(alert_req),
    .CONV_ENABLE(conv_en), .NVM_STORE(nvm_store), .CMD_STROBE(cmd_strobe), .CMD(cmd), .SLAVE_ADDR(slave_addr));
  pmbfe_host_model host_u (.clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [25:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  always @(negedge ref_clk) begin
    if (cmd_strobe === 1'b1 && notes.size() == 0) chk(1'b1, 1'b0, "stray strobe");
    else if (cmd_strobe === 1'b1) chk({nvm_store, cmd}, notes.pop_front(), "command");
    else if (nvm_store !== 1'b0) chk(nvm_store, 1'b0, "store alone");
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, b);
    c = c ^ b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task automatic do_reset(input logic [3:0] lo, hi);
    strap_lo = lo;
    strap_hi = hi;
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    own = (lo > 4'h7 || hi > 4'h7) ? 7'h7F : {1'b0, hi[2:0], lo[2:0]};
    repeat (4) @(negedge ref_clk);
    chk(slave_addr, own, "address");
  endtask : do_reset
  // pec: 0 none, 1 good check byte, 2 corrupted check byte
  task automatic xw(input logic [6:0] a, input logic [7:0] q[$], input int pec, input logic ack_exp);
    logic [7:0] c;
    logic [15:0] d;
    logic ack;
    d = (q.size() > 2) ? {q[2], q[1]} : (q.size() > 1) ? {8'h00, q[1]} : 16'h0000;
    if (ack_exp && pec != 2)
      notes.push_back({q[0] == CMD_STORE_DEFAULT_ALL || q[0] == CMD_STORE_USER_ALL, q[0], d, pec == 1});
    c = crc8(8'h00, {a, 1'b0});
    host_u.start();
    host_u.wbyte({a, 1'b0}, ack);
    chk(ack, ack_exp, "address ack");
    if (ack) foreach (q[i]) begin
      c = crc8(c, q[i]);
      host_u.wbyte(q[i], ack);
      chk(ack, 1'b1, "data ack");
    end
    if (ack && pec > 0) host_u.wbyte(c ^ 8'(pec - 1), ack);
    host_u.stop();
  endtask : xw
  task automatic xr(input logic [7:0] code, exp);
    logic [7:0] b;
    logic ack;
    host_u.start();
    host_u.wbyte({own, 1'b0}, ack);
    host_u.wbyte(code, ack);
    host_u.start();
    host_u.wbyte({own, 1'b1}, ack);
    host_u.rbyte(1'b1, b);
    chk(b, exp, "read value");
    host_u.rbyte(1'b0, b);
    chk(b, crc8(crc8(crc8(crc8(8'h00, {own, 1'b0}), code), {own, 1'b1}), exp), "read check");
    host_u.stop();
  endtask : xr
  task automatic xa(input logic ack_exp);
    logic [7:0] b;
    logic ack;
    host_u.start();
    host_u.wbyte({ADDR_ALERT_RESP, 1'b1}, ack);
    chk(ack, ack_exp, "alert ack");
    if (ack) host_u.rbyte(1'b0, b);
    if (ack) chk(b, {own, 1'b0}, "alert address");
    host_u.stop();
  endtask : xa
  task automatic cv(input logic [7:0] cfg, op);
    for (int p = 0; p < 2; p++) begin
      onoff = p[0];
      repeat (3) @(negedge ref_clk);
      chk(conv_en, !cfg[ONOFF_PU] | ((!cfg[ONOFF_CMD] | op[OPER_ON])
        & (!cfg[ONOFF_CPR] | p[0] == cfg[ONOFF_POL])), "enable");
    end
  endtask : cv
  initial begin
    repeat (98000) @(posedge ref_clk);
    chk(1'b1, 1'b0, "timeout");
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h7E3F685E));
    @(negedge ref_clk);
    // high digit from 2 up keeps the own address off the alert response address
    do_reset(4'($urandom_range(7)), 4'($urandom_range(7, 2)));
    cv(ONOFF_CONFIG_RST, OPERATION_RST);
    xr(CMD_ONOFF_CONFIG, 8'h16);
    strap_hi = 4'hF;
    repeat (3) @(negedge ref_clk);
    chk(slave_addr, own, "address held");
    xw(own ^ 7'h01, {8'h03}, 0, 1'b0);
    xw(own, {CMD_ONOFF_CONFIG, 8'h14}, 1, 1'b1);
    cv(8'h14, OPERATION_RST);
    xw(own, {CMD_OPERATION, 8'h80}, 2, 1'b1);
    xw(own, {CMD_OPERATION, 8'h80}, 0, 1'b1);
    xw(own, {CMD_ONOFF_CONFIG, 8'h1E}, 0, 1'b1);
    cv(8'h1E, 8'h80);
    xw(own, {CMD_VOUT_COMMAND, 8'($urandom_range(255)), 8'($urandom_range(255))}, 1, 1'b1);
    xa(1'b0);
    alert_req = 1'b1;
    @(negedge ref_clk);
    alert_req = 1'b0;
    @(negedge ref_clk);
    chk(alert_oe, 1'b1, "alert raised");
    xa(1'b1);
    chk(alert_oe, 1'b0, "alert cleared");
    xw(own, {CMD_STORE_DEFAULT_ALL}, 0, 1'b1);
    // standard rate costs over four times the cycles, so only one short frame
    host_u.lo_cyc = 470;
    host_u.hi_cyc = 400;
    xw(own, {CMD_STORE_USER_ALL}, 0, 1'b1);
    host_u.lo_cyc = 130;
    host_u.hi_cyc = 70;
    do_reset(4'h9, 4'($urandom_range(7)));
    xw(own, {8'h03}, 0, 1'b1);
    do_reset(4'h0, 4'h0);
    xw(own, {8'h03}, 1, 1'b1);
    repeat (5) @(negedge ref_clk);
    chk(notes.size(), 0, "missing strobes");
    tally_and_finish();
  end
endmodule : pmbus_slave_front_end_test
